// ---- bench/test_ucf_top.sv ----
// Register level bench for the serial frame control block
module test_ucf_top
  import ucf_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] avs_address = 14'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rxd, txd, drive, rx_irq;
  logic cts_n = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  int irq_cnt = 0; // Receive requests seen
  int low_cnt = 0; // Clocks with the line low
  logic [31:0] rd;
  logic [15:0] got, fb;
  int n;
  // Transmit table: control A, control B, data
  logic [7:0] ta [4] = '{8'h80, 8'h92, 8'h98, 8'h90};
  logic [7:0] tb [4] = '{8'h00, 8'h00, 8'h00, 8'h58};
  logic [7:0] td [4] = '{8'hA5, 8'h3C, 8'h07, 8'hC3};
  int fexp [4] = '{4, 2, 2, 1}; // Requests per filter mode
  ucf_top ucf_top_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd),
    .cts_n(cts_n), .txd(txd), .transceiver_drive_signal(drive), .rx_irq(rx_irq));
  ucf_node ucf_node_i (.clk(clk), .txd(txd), .rxd(rxd));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Event counters for requests and line lows
  always @(posedge clk)
  begin
    irq_cnt += int'(rx_irq === 1'b1);
    low_cnt += int'(txd !== 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  // One Avalon access; waits for waitrequest low, a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] val);
    tests_run++;
    if (val !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, val);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Expected transmit bits after the start bit
  function automatic logic [15:0] fbits(input logic [7:0] d, a, b, output int cnt);
    logic [15:0] f;
    int i;
    f = {8'hFF, d};
    i = 8;
    f[i] = b[4];
    i += int'(b[6]);
    f[i] = ^d ^ a[3];
    i += int'(a[4]);
    f[i] = 1'b1;
    f[i + 1] = 1'b1;
    cnt = i + 1 + int'(a[1]);
    return f;
  endfunction : fbits
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values, readback, unmapped place
    bus(0, IDX_CTL_A, 0); chk("ctl_a reset", 32'h0, rd);
    bus(0, IDX_CTL_B, 0); chk("ctl_b reset", 32'h0, rd);
    bus(1, IDX_CTL_A, 8'h5A); bus(0, IDX_CTL_A, 0); chk("ctl_a rw", 32'h5A, rd);
    bus(1, 12'hF44, 8'hFF); bus(0, 12'hF44, 0); chk("unmapped", 32'h0, rd);
    $display("test registers done");
    // Frame formats; CTS is high but ungated throughout
    cts_n <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      bus(1, IDX_CTL_A, 0);
      bus(1, IDX_CTL_B, tb[k]);
      bus(1, IDX_CTL_A, ta[k]);
      chk("drive idle", {31'h0, tb[k][3]}, {31'h0, drive});
      bus(1, IDX_DATA, td[k]);
      fb = fbits(td[k], ta[k], tb[k], n);
      ucf_node_i.recv(n, got);
      chk("drive busy", {31'h0, !tb[k][3]}, {31'h0, drive});
      chk("frame", fb & 16'((1 << n) - 1), got);
      repeat (40) @(posedge clk);
    end
    $display("test transmit done");
    // Gated transmitter holds the byte until CTS falls
    bus(1, IDX_CTL_A, 0); bus(1, IDX_CTL_B, 0); bus(1, IDX_CTL_A, 8'hA0);
    low_cnt = 0;
    bus(1, IDX_DATA, 8'h5A);
    repeat (200) @(posedge clk);
    chk("gated line", 32'h0, low_cnt);
    cts_n <= 1'b0;
    ucf_node_i.recv(9, got);
    chk("gated frame", 32'h15A, got);
    repeat (40) @(posedge clk);
    // Break after the line has gone idle
    bus(1, IDX_CTL_A, 8'h84);
    repeat (4) @(posedge clk);
    chk("break line", 32'h0, {31'h0, txd});
    bus(1, IDX_CTL_A, 8'h80);
    repeat (4) @(posedge clk);
    chk("break end", 32'h1, {31'h0, txd});
    $display("test flow and break done");
    // Loopback: line stays idle, byte comes back
    bus(1, IDX_CTL_A, 0); bus(1, IDX_CTL_A, 8'hC1);
    low_cnt = 0;
    irq_cnt = 0;
    bus(1, IDX_DATA, 8'h96);
    repeat (300) @(posedge clk);
    bus(0, IDX_DATA, 0);
    chk("loop data", 32'h96, rd);
    chk("loop line", 32'h0, low_cnt);
    chk("loop irq", 32'h1, irq_cnt);
    $display("test loopback done");
    // Address filter modes, then receiver off
    bus(1, IDX_CTL_A, 0); bus(1, IDX_ADDR_CMP, 8'h21);
    for (int m = 0; m < 5; m++)
    begin
      bus(1, IDX_CTL_A, 0);
      bus(1, IDX_CTL_B, {m[1], 1'b1, m[0], 5'h0});
      bus(1, IDX_CTL_A, m < 4 ? 8'h40 : 8'h00);
      irq_cnt = 0;
      ucf_node_i.send(8'h21, 1, 1); repeat (20) @(posedge clk); bus(0, IDX_DATA, 0);
      ucf_node_i.send(8'h44, 1, 0); repeat (20) @(posedge clk); bus(0, IDX_DATA, 0);
      ucf_node_i.send(8'h37, 1, 1); repeat (20) @(posedge clk); bus(0, IDX_DATA, 0);
      ucf_node_i.send(8'h55, 1, 0); repeat (20) @(posedge clk); bus(0, IDX_DATA, 0);
      if (m == 0)
        chk("rx data", 32'h55, rd);
      chk("filter irqs", m < 4 ? fexp[m] : 0, irq_cnt);
    end
    $display("test receive done");
    // Divider as timer with receiver off; window spans exactly one hundred clocks
    bus(1, IDX_DIVISOR, 8'h0A); bus(1, IDX_CTL_B, 8'h04);
    irq_cnt = 0;
    repeat (97) @(posedge clk);
    bus(1, IDX_CTL_B, 0); repeat (4) @(posedge clk);
    chk("timer irqs", 32'h0A, irq_cnt);
    $display("test timer done");
    tally_and_finish();
  end
endmodule : test_ucf_top

// ---- bench/ucf_checker.sv ----
// Protocol and line checker for the serial frame control block
module ucf_checker
  import ucf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic txd,
  input wire logic transceiver_drive_signal,
  input wire logic rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ucf_ctl_a_t ctl_a_q; // Shadow of control A
  logic pol_q; // Shadow of drive polarity
  wire logic [11:0] idx = avs_address[13:2];
  wire logic acc_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic acc_r = avs_read && !avs_waitrequest;
  wire logic mapped = idx inside {IDX_DATA, IDX_STATUS, IDX_CTL_A, IDX_CTL_B,
    IDX_ADDR_CMP, IDX_DIVISOR};
  wire logic brk = ctl_a_q.force_line_low && !ctl_a_q.loopback_on; // Break on the pin
  wire logic act = transceiver_drive_signal ^ pol_q; // Drive asserted
  // Judged with no loopback and an unblocked transmitter; lead timing assumes divisor one
  wire logic go = ctl_a_q.transmitter_on && !(ctl_a_q.flow_gate_on && cts_n) && !brk &&
    !ctl_a_q.loopback_on;
  ////////////////////////////////////////////////////////////////////////////
  // Shadows follow writes at the accepting edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl_a_q <= CTL_A_RESET;
      pol_q <= CTL_B_RESET[3];
    end
    else if (acc_w && idx == IDX_CTL_A)
      ctl_a_q <= avs_writedata[7:0];
    else if (acc_w && idx == IDX_CTL_B)
      pol_q <= avs_writedata[3];
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_rst_out;
    $past(rst) |-> avs_waitrequest && txd && !rx_irq && avs_readdata == 32'h0;
  endproperty
  property p_irq_pulse;
    rx_irq |=> !rx_irq;
  endproperty
  property p_break;
    brk && $past(brk) && $past(brk, 2) |-> !txd;
  endproperty
  property p_idle;
    !act && !brk |-> txd;
  endproperty
  property p_unmapped;
    acc_r && !mapped |-> avs_readdata == 32'h0;
  endproperty
  property p_ctl_rd;
    acc_r && idx == IDX_CTL_A |-> avs_readdata == {24'h0, ctl_a_q};
  endproperty
  property p_lead;
    $rose(act) && go |-> txd [*8] ##1 txd [*8] ##[1:17] !txd;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  a_wait_ans: assert property (p_wait_ans) else $error("waitrequest not answered");
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than a cycle");
  a_break: assert property (p_break) else $error("line not low in break");
  a_idle: assert property (p_idle) else $error("line low while drive idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ctl_rd: assert property (p_ctl_rd) else $error("control A readback wrong");
  a_lead: assert property (p_lead) else $error("drive lead out of range");
  c_frame: cover property ($rose(act) && go);
  c_irq: cover property (rx_irq);
  c_break: cover property (brk && !txd);
endmodule : ucf_checker

bind ucf_top ucf_checker ucf_checker_i (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rxd(rxd), .cts_n(cts_n), .txd(txd),
  .transceiver_drive_signal(transceiver_drive_signal), .rx_irq(rx_irq));

// ---- bench/ucf_node.sv ----
// Remote serial node: drives the receive line, samples the transmit line
module ucf_node
(
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16; // Clocks per bit at divisor one
  initial rxd = 1'b1; // Line idles at mark
  // Start, data lsb first, ninth bit if used, stop
  task automatic send(input logic [7:0] d, input logic use9, input logic nb);
    logic [10:0] f;
    f = {1'b1, use9 ? nb : 1'b1, d, 1'b0}; // ninth bit one marks address
    @(posedge clk);
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask : send
  // Waits for a start bit, then samples n bits at their centres
  task automatic recv(input int n, output logic [15:0] bits);
    int t;
    bits = 16'h0;
    t = 0;
    while (txd !== 1'b0 && t < 4000)
    begin
      @(posedge clk);
      t++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT) @(posedge clk);
      bits[i] = txd;
    end
  endtask : recv
endmodule : ucf_node

// ---- logic/ucf_baud.sv ----
// Baud divider: sixteen-times oversample tick and live count
module ucf_baud
  import ucf_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] reload,
  output logic tick,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_q;
  logic tick_q;
  wire at_end = (count_q <= WIDTH'(1)); // Zero or one both reload

  ////////////////////////////////////////////////////////////////////////////////
  // Count down, reload and pulse at the end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      count_q <= at_end ? reload : count_q - WIDTH'(1);
      tick_q <= at_end;
    end
  end

  assign tick = tick_q;
  assign count = count_q;

endmodule : ucf_baud

// ---- logic/ucf_pkg.sv ----
// Shared constants, register map and carrier types of the serial frame control block
package ucf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_DATA = 12'hF40; // Transmit hold / receive data
  localparam logic [11:0] IDX_STATUS = 12'hF41; // Live status
  localparam logic [11:0] IDX_CTL_A = 12'hF42; // serial_control_a
  localparam logic [11:0] IDX_CTL_B = 12'hF43; // serial_control_b
  localparam logic [11:0] IDX_ADDR_CMP = 12'hF45; // Station address compare
  localparam logic [11:0] IDX_DIVISOR = 12'hF46; // 16-bit baud divisor

  // Reset values
  localparam logic [7:0] CTL_A_RESET = 8'h00;
  localparam logic [7:0] CTL_B_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;

  // Address filter mode codes
  localparam logic [1:0] FILT_ALL = 2'h0;
  localparam logic [1:0] FILT_ADDR = 2'h1;
  localparam logic [1:0] FILT_MATCH_ALL = 2'h2;
  localparam logic [1:0] FILT_MATCH_DATA = 2'h3;

  // Timing counts, in baud ticks or whole bits
  localparam logic [3:0] SUB_LAST = 4'hF; // Sixteen ticks per bit
  localparam logic [3:0] SUB_MID = 4'h7; // Start bit centre check
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3; // Infrared pulse length
  localparam logic [3:0] LEAD_BITS = 4'h1; // Drive lead, whole bits
  localparam logic [3:0] FRAME_MAX = 4'hD; // Start+8+mp+parity+2 stop

  ////////////////////////////////////////////////////////////////////////////////
  // Control register A, msb first
  typedef struct packed {
    logic transmitter_on;
    logic receiver_on;
    logic flow_gate_on;
    logic parity_on;
    logic parity_odd;
    logic force_line_low;
    logic two_stop;
    logic loopback_on;
  } ucf_ctl_a_t;

  // Control register B, msb first
  typedef struct packed {
    logic mode_hi;
    logic nine_bit_mode_on;
    logic mode_lo;
    logic ninth_bit_value;
    logic driver_output_polarity;
    logic divider_timer_control;
    logic rx_data_irq_mask;
    logic infrared_codec_on;
  } ucf_ctl_b_t;

  // Status register, msb first
  typedef struct packed {
    logic rx_avail;
    logic parity_err;
    logic overrun_err;
    logic framing_err;
    logic break_seen;
    logic tx_hold_empty;
    logic tx_all_empty;
    logic cts_level;
  } ucf_status_t;

endpackage : ucf_pkg

// ---- logic/ucf_top.sv ----
// Serial frame control: registers, transmitter, receiver and address filter
module ucf_top
  import ucf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxd,
  input wire logic cts_n,
  output logic txd,
  output logic transceiver_drive_signal,
  output logic rx_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_LEAD = 4'b0010,
    TX_SHIFT = 4'b0100,
    TX_TAIL = 4'b1000
  } ucf_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } ucf_rx_state_t;

  ucf_ctl_a_t ctl_a_q; // uart_control_a
  ucf_ctl_b_t ctl_b_q; // uart_control_b
  ucf_status_t stat; // Assembled status view
  logic [7:0] addr_cmp_q; // Station address
  logic [15:0] divisor_q; // Baud reload value
  logic wait_q; // Waitrequest, high until answer
  logic [31:0] rdata_q; // Read data
  logic [7:0] hold_q; // Transmit hold byte
  logic hold_full_q; // Hold byte waiting
  ucf_tx_state_t tx_st_q;
  logic [12:0] frame_q; // Outgoing frame, lsb first
  logic [3:0] tx_len_q; // Bits in frame
  logic [3:0] tx_idx_q; // Current bit
  logic [3:0] tx_sub_q; // Tick within bit
  logic line_q; // Serial line before codec
  logic txd_q;
  logic drive_on_q; // Drive envelope, true sense
  logic drive_pin_q;
  ucf_rx_state_t rx_st_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_idx_q;
  logic [10:0] rx_bits_q; // Received body plus stop
  logic rx_done_q; // Character complete pulse
  logic [7:0] rx_data_q;
  logic rda_q, pe_q, oe_q, fe_q, brk_q;
  logic in_frame_q; // Last address matched
  logic irq_q;
  logic [2:0] rxd_s_q, cts_s_q; // Three-stage pin synchronisers
  logic rxd_lv_q, cts_lv_q; // Filtered pin levels
  logic [3:0] ir_cnt_q; // Infrared stretch counter
  logic tick;
  logic [15:0] baud_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire [11:0] idx = avs_address[13:2];
  wire req = avs_read | avs_write;
  wire take = req & ~wait_q; // Edge at which master samples answer
  wire wr = take & avs_write;
  wire rd = take & avs_read;
  wire hit_data = (idx == IDX_DATA);
  wire hit_stat = (idx == IDX_STATUS);
  wire hit_a = (idx == IDX_CTL_A);
  wire hit_b = (idx == IDX_CTL_B);
  wire hit_cmp = (idx == IDX_ADDR_CMP);
  wire hit_div = (idx == IDX_DIVISOR);
  wire lane0 = avs_byteenable[0];
  wire lane1 = avs_byteenable[1];
  wire tx_load = wr & hit_data & lane0;
  wire rx_read = rd & hit_data;
  wire [15:0] div_view = ctl_b_q.divider_timer_control ? baud_count : divisor_q;
  wire [7:0] rd_byte = hit_data ? rx_data_q :
                       hit_stat ? stat :
                       hit_a ? ctl_a_q :
                       hit_b ? ctl_b_q :
                       hit_cmp ? addr_cmp_q : 8'h00;
  wire [31:0] rd_word = hit_div ? {16'h0000, div_view} : {24'h000000, rd_byte};

  // Status view
  assign stat = '{rx_avail: rda_q, parity_err: pe_q, overrun_err: oe_q,
                  framing_err: fe_q, break_seen: brk_q, tx_hold_empty: ~hold_full_q,
                  tx_all_empty: (tx_st_q == TX_IDLE) & ~hold_full_q,
                  cts_level: cts_lv_q};

  // Single wait state: answer one edge after the request appears
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q)
        rdata_q <= rd_word; // Unmapped reads return zero
    end
  end

  // Configuration writes; settings assumed stable while enabled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl_a_q <= CTL_A_RESET;
      ctl_b_q <= CTL_B_RESET;
      addr_cmp_q <= 8'h00;
      divisor_q <= DIVISOR_RESET;
    end
    else if (wr)
    begin
      if (hit_a & lane0)
        ctl_a_q <= avs_writedata[7:0];
      if (hit_b & lane0)
        ctl_b_q <= avs_writedata[7:0];
      if (hit_cmp & lane0)
        addr_cmp_q <= avs_writedata[7:0];
      if (hit_div & lane0)
        divisor_q[7:0] <= avs_writedata[7:0];
      if (hit_div & lane1)
        divisor_q[15:8] <= avs_writedata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxd_s_q <= 3'h7;
      cts_s_q <= 3'h7;
      rxd_lv_q <= 1'b1;
      cts_lv_q <= 1'b1;
    end
    else
    begin
      rxd_s_q <= {rxd_s_q[1:0], rxd};
      cts_s_q <= {cts_s_q[1:0], cts_n};
      if (rxd_s_q[1] == rxd_s_q[2])
        rxd_lv_q <= rxd_s_q[2];
      if (cts_s_q[1] == cts_s_q[2])
        cts_lv_q <= cts_s_q[2];
    end
  end

  // Baud divider, shared by both directions and the timer use
  ucf_baud #(.WIDTH(16)) u_baud (
    .clk(clk),
    .rst(rst),
    .reload(divisor_q),
    .tick(tick),
    .count(baud_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit frame builder
  wire tx_run = ctl_a_q.transmitter_on & (~ctl_a_q.flow_gate_on | ~cts_lv_q);
  wire par_bit = ^hold_q ^ ctl_a_q.parity_odd;
  logic [12:0] frame_d;
  logic [3:0] len_d;
  always_comb
  begin
    frame_d = '1; // Unused tail reads as stop level
    frame_d[0] = 1'b0;
    frame_d[8:1] = hold_q;
    len_d = 4'h9;
    if (ctl_b_q.nine_bit_mode_on)
    begin
      frame_d[len_d] = ctl_b_q.ninth_bit_value;
      len_d = len_d + 4'h1;
    end
    if (ctl_a_q.parity_on)
    begin
      frame_d[len_d] = par_bit;
      len_d = len_d + 4'h1;
    end
    len_d = len_d + (ctl_a_q.two_stop ? 4'h2 : 4'h1);
  end

  wire bit_end = tick & (tx_sub_q == SUB_LAST);
  wire can_go = hold_full_q & tx_run;

  // Transmit sequencer, including drive envelope
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_st_q <= TX_IDLE;
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
      frame_q <= '1;
      tx_len_q <= 4'h0;
      tx_idx_q <= 4'h0;
      tx_sub_q <= 4'h0;
      line_q <= 1'b1;
      drive_on_q <= 1'b0;
    end
    else
    begin
      if (tx_load)
        hold_q <= avs_writedata[7:0];
      if (tick)
        tx_sub_q <= tx_sub_q + 4'h1;
      if (ctl_a_q.force_line_low) // Break overrides everything
      begin
        tx_st_q <= TX_IDLE;
        line_q <= 1'b0;
        drive_on_q <= 1'b1;
        hold_full_q <= hold_full_q | tx_load;
      end
      else
      begin
        case (tx_st_q)
          TX_IDLE:
          begin
            line_q <= 1'b1;
            drive_on_q <= tx_load | (drive_on_q & hold_full_q);
            hold_full_q <= hold_full_q | tx_load;
            if (tx_load) // Drive rises on the write
            begin
              tx_st_q <= TX_LEAD;
              tx_sub_q <= 4'h0;
              tx_idx_q <= 4'h0;
            end
            else if (can_go)
            begin
              tx_st_q <= TX_LEAD;
              tx_sub_q <= 4'h0;
              tx_idx_q <= 4'h0;
              drive_on_q <= 1'b1;
            end
          end
          TX_LEAD:
          begin
            hold_full_q <= 1'b1;
            if (bit_end)
              tx_idx_q <= tx_idx_q + 4'h1;
            // Whole lead bit elapsed and allowed to send
            if (tx_idx_q >= LEAD_BITS && tx_run)
            begin
              tx_st_q <= TX_SHIFT;
              frame_q <= frame_d;
              tx_len_q <= len_d;
              tx_idx_q <= 4'h0;
              tx_sub_q <= 4'h0;
              hold_full_q <= tx_load;
              line_q <= 1'b0;
            end
          end
          TX_SHIFT:
          begin
            hold_full_q <= hold_full_q | tx_load;
            if (bit_end)
            begin
              if (tx_idx_q == tx_len_q - 4'h1)
              begin
                tx_st_q <= TX_TAIL;
                line_q <= 1'b1;
              end
              else
              begin
                tx_idx_q <= tx_idx_q + 4'h1;
                line_q <= frame_q[tx_idx_q + 4'h1];
              end
            end
          end
          TX_TAIL:
          begin
            // One clock after the last stop, unless another byte waits and the transmitter may run
            hold_full_q <= hold_full_q | tx_load;
            if ((hold_full_q | tx_load) & tx_run)
            begin
              tx_st_q <= TX_LEAD;
              tx_idx_q <= LEAD_BITS;
            end
            else
            begin
              tx_st_q <= TX_IDLE;
              drive_on_q <= 1'b0;
            end
          end
          default:
          begin
            tx_st_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line shaping: infrared pulses or plain levels, polarity of drive
  wire loop = ctl_a_q.loopback_on;
  wire ir = ctl_b_q.infrared_codec_on;
  wire ir_tx = ~line_q & (tx_sub_q < IR_PULSE_TICKS); // Short high pulse per zero
  wire pin_tx = loop ? ~ir : (ir ? ir_tx : line_q);
  wire ir_rx = (ir_cnt_q == 4'h0); // Decoded level, low while stretched
  wire rx_line = loop ? line_q : (ir ? ir_rx : rxd_lv_q);

  // Output stage and infrared receive stretch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txd_q <= 1'b1;
      drive_pin_q <= 1'b0;
      ir_cnt_q <= 4'h0;
    end
    else
    begin
      txd_q <= pin_tx;
      drive_pin_q <= drive_on_q ^ ctl_b_q.driver_output_polarity;
      // A high pulse reads as one zero bit period
      if (rxd_lv_q & ir)
        ir_cnt_q <= SUB_LAST;
      else if (tick & (ir_cnt_q != 4'h0))
        ir_cnt_q <= ir_cnt_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive framer; body length mirrors the transmitter
  wire rx_mp = ctl_b_q.nine_bit_mode_on;
  wire [3:0] rx_len = 4'h9 + {3'h0, rx_mp} + {3'h0, ctl_a_q.parity_on}; // Body plus stop
  wire [3:0] par_pos = rx_mp ? 4'h9 : 4'h8;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_st_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_bits_q <= '0;
      rx_done_q <= 1'b0;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (tick)
        rx_sub_q <= rx_sub_q + 4'h1;
      if (~ctl_a_q.receiver_on) // Disabled receiver drops any frame
        rx_st_q <= RX_IDLE;
      else
      begin
        case (rx_st_q)
          RX_IDLE:
          begin
            if (~rx_line)
            begin
              rx_st_q <= RX_START;
              rx_sub_q <= 4'h0;
            end
          end
          RX_START:
          begin
            if (tick & (rx_sub_q == SUB_MID))
            begin
              rx_st_q <= rx_line ? RX_IDLE : RX_BITS;
              rx_sub_q <= 4'h0;
              rx_idx_q <= 4'h0;
            end
          end
          RX_BITS:
          begin
            if (tick & (rx_sub_q == SUB_LAST))
            begin
              rx_bits_q[rx_idx_q] <= rx_line;
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_len - 4'h1)
              begin
                rx_st_q <= RX_IDLE;
                rx_done_q <= 1'b1;
              end
            end
          end
          default:
          begin
            rx_st_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Character checks and address filter
  wire [7:0] got = rx_bits_q[7:0];
  wire is_addr = rx_mp & rx_bits_q[8];
  wire stop_ok = rx_bits_q[rx_len - 4'h1];
  wire par_bad = ctl_a_q.parity_on & (^got ^ ctl_a_q.parity_odd ^ rx_bits_q[par_pos]);
  wire is_brk = ~stop_ok & ~|(rx_bits_q & ((11'h001 << rx_len) - 11'h001));
  wire match = (got == addr_cmp_q);
  wire [1:0] mode = {ctl_b_q.mode_hi, ctl_b_q.mode_lo};
  wire err = par_bad | ~stop_ok | is_brk;
  logic want;
  always_comb
  begin
    case (mode)
      FILT_ALL: want = 1'b1;
      FILT_ADDR: want = is_addr;
      FILT_MATCH_ALL: want = is_addr ? match : in_frame_q;
      FILT_MATCH_DATA: want = ~is_addr & in_frame_q;
      default: want = 1'b1;
    endcase
    if (~rx_mp) // Filter inactive in ordinary framing
      want = 1'b1;
  end
  wire keep = want | err;
  wire timer_irq = ~ctl_a_q.receiver_on & ctl_b_q.divider_timer_control & tick;

  // Receive data, flags and request; new events win over a clearing read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_data_q <= 8'h00;
      {rda_q, pe_q, oe_q, fe_q, brk_q} <= 5'h00;
      in_frame_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (rx_read)
      begin
        rda_q <= 1'b0;
        {pe_q, oe_q, fe_q, brk_q} <= 4'h0;
      end
      if (rx_done_q & is_addr)
        in_frame_q <= match;
      if (rx_done_q & keep)
      begin
        if (rda_q & ~rx_read)
          oe_q <= 1'b1; // Held byte survives an overrun
        else
        begin
          rx_data_q <= got;
          rda_q <= 1'b1;
          pe_q <= par_bad;
          fe_q <= ~stop_ok;
          brk_q <= is_brk;
        end
      end
      // Data requests unless masked; errors always
      irq_q <= timer_irq |
               (rx_done_q & ((want & ~ctl_b_q.rx_data_irq_mask) | err));
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign txd = txd_q;
  assign transceiver_drive_signal = drive_pin_q;
  assign rx_irq = irq_q;

endmodule : ucf_top
